/* ptb_pkg.sv */
package ptb_pkg;

  // register byte addresses
  localparam logic [11:0] PTB_ADDR_CTRL = 12'h000;
  localparam logic [11:0] PTB_ADDR_STAT = 12'h004;
  localparam logic [11:0] PTB_ADDR_MASK = 12'h008;

  // timebase_control field positions
  localparam int PTB_CTRL_FLAG_BIT = 7;
  localparam int PTB_CTRL_RATE_LSB = 4;
  localparam int PTB_CTRL_ACK_BIT = 3;
  localparam int PTB_CTRL_IE_BIT = 2;
  localparam int PTB_CTRL_ON_BIT = 1;
  localparam int PTB_RATE_W = 3;
  localparam logic [7:0] PTB_CTRL_RESET = 8'h00;

  // event status / mask layout
  localparam int PTB_EVT_W = 2;
  localparam int PTB_EVT_PERIOD_BIT = 0;
  localparam int PTB_EVT_REFUSED_BIT = 1;
  localparam logic [1:0] PTB_STAT_RESET = 2'h0;
  localparam logic [1:0] PTB_MASK_RESET = 2'h0;

  // divider chain
  localparam int PTB_DIV_STAGES = 15;
  localparam int PTB_PRESCALE_DIV = 128;

  // log2 of the divider for each rate_select code 0..7
  localparam logic [3:0] PTB_TAP_LOG2 [8] = '{
    4'hf, 4'hd, 4'hb, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3
  };

endpackage : ptb_pkg

/* ptb_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

module ptb_prescaler
#(
  parameter int PRESCALE = ptb_pkg::PTB_PRESCALE_DIV
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // crystal clock pin and option
  input wire logic crystal_clock,
  input wire logic prescale128_option,
  input wire logic run,
  // one-cycle enable per counter clock
  output logic tick
);
  import ptb_pkg::*;

  localparam int PW = $clog2(PRESCALE);

  generate
    if (PRESCALE < 2 || (1 << PW) != PRESCALE)
    begin : g_bad_prescale
      $error("prescale must be a power of two");
    end
  endgenerate

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic [PW-1:0] pre_q;
  logic [PW-1:0] pre_d;
  wire xrise = sync2_q & ~prev_q;
  wire pre_wrap = &pre_q;

  // pre counter cleared to zero while stopped so a restart is repeatable
  assign pre_d = !run ? '0 : (xrise ? pre_q + 1'b1 : pre_q);
  // extra divide only when the option selects it
  assign tick = run & xrise & (!prescale128_option | pre_wrap);

  // crystal edge is only seen after two flops; crystal must be < pclk/2
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      pre_q <= '0;
    end
    else
    begin
      sync1_q <= crystal_clock;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      pre_q <= pre_d;
    end
  end

endmodule : ptb_prescaler

`default_nettype wire

/* ptb_timebase.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - counter held at zero while disabled
// - fifteen divider stages, eight selectable taps
// - rate code maps to documented divider values
// - tap overflow sets the period flag
// - flag and enable raise the interrupt
// - acknowledge write of one clears flag
// - first event at half, then full period
// - crystal clock, optionally divided by 128
// - stop halts counting unless oscillator runs
// - register locked in wait and stop
// - reset clears enable and interrupt enable
module ptb_timebase
#(
  parameter int STAGES = ptb_pkg::PTB_DIV_STAGES
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter clock source
  input wire logic crystal_clock,
  // configuration options
  input wire logic prescale128_option,
  input wire logic osc_run_in_stop,
  // power modes
  input wire logic wait_mode,
  input wire logic stop_mode,
  // interrupt
  output logic irq
);
  import ptb_pkg::*;

  generate
    if (STAGES < PTB_DIV_STAGES)
    begin : g_bad_stages
      $error("divider needs at least fifteen stages");
    end
  endgenerate

  // apb decode
  wire access = psel & penable;
  wire setup = psel & ~penable;
  wire low_power = wait_mode | stop_mode;
  wire hit_ctrl = paddr == PTB_ADDR_CTRL;
  wire hit_stat = paddr == PTB_ADDR_STAT;
  wire hit_mask = paddr == PTB_ADDR_MASK;
  wire mapped = hit_ctrl | hit_stat | hit_mask;
  wire refused = access & low_power;
  wire acc_ok = access & ~low_power & mapped;
  wire wr_ctrl = acc_ok & pwrite & hit_ctrl;
  wire wr_mask = acc_ok & pwrite & hit_mask;
  wire rd_stat = acc_ok & ~pwrite & hit_stat;

  // control state
  logic on_q;
  logic ie_q;
  logic flag_q;
  logic flag_d;
  logic [PTB_RATE_W-1:0] rate_q;
  logic [PTB_EVT_W-1:0] stat_q;
  logic [PTB_EVT_W-1:0] stat_d;
  logic [PTB_EVT_W-1:0] mask_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;

  // divider chain
  logic [STAGES-1:0] cnt_q;
  logic [STAGES-1:0] cnt_d;
  logic [STAGES-1:0] cnt_inc;
  logic tick;
  logic run;
  logic tap_evt;
  logic [3:0] tap;

  // stop without the oscillator freezes the chain
  assign run = on_q & ~(stop_mode & ~osc_run_in_stop);

  ptb_prescaler #(
    .PRESCALE(PTB_PRESCALE_DIV)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .crystal_clock(crystal_clock),
    .prescale128_option(prescale128_option),
    .run(run),
    .tick(tick)
  );

  assign tap = PTB_TAP_LOG2[rate_q];
  assign cnt_inc = cnt_q + {{(STAGES-1){1'b0}}, 1'b1};
  assign cnt_d = !on_q ? '0 : (tick ? cnt_inc : cnt_q);
  // fire when the bit below the tap rises: half period first, then full
  assign tap_evt = tick & cnt_inc[tap - 4'h1] & ~cnt_q[tap - 4'h1];

  wire ack_wr = wr_ctrl & pwdata[PTB_CTRL_ACK_BIT];
  // set wins so a period is never lost
  assign flag_d = tap_evt | (flag_q & ~ack_wr);

  // only bits the reader actually saw are cleared
  wire [PTB_EVT_W-1:0] stat_set = {refused, tap_evt};
  wire [PTB_EVT_W-1:0] stat_seen = rd_stat ? prdata_q[PTB_EVT_W-1:0] : '0;
  assign stat_d = stat_set | (stat_q & ~stat_seen);

  wire [7:0] ctrl_view = {flag_q, rate_q, 1'b0, ie_q, on_q, 1'b0};

  assign rd_mux = hit_ctrl ? {24'h0, ctrl_view} :
                  hit_stat ? {{(32-PTB_EVT_W){1'b0}}, stat_q} :
                  hit_mask ? {{(32-PTB_EVT_W){1'b0}}, mask_q} : 32'h0;

  // zero-wait slave; data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access & (low_power | ~mapped);
  assign prdata = prdata_q;
  assign irq = (flag_q & ie_q) | (|(stat_q & mask_q));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      on_q <= PTB_CTRL_RESET[PTB_CTRL_ON_BIT];
      ie_q <= PTB_CTRL_RESET[PTB_CTRL_IE_BIT];
      rate_q <= PTB_CTRL_RESET[PTB_CTRL_RATE_LSB +: PTB_RATE_W];
      flag_q <= PTB_CTRL_RESET[PTB_CTRL_FLAG_BIT];
    end
    else
    begin
      flag_q <= flag_d;
      if (wr_ctrl)
      begin
        on_q <= pwdata[PTB_CTRL_ON_BIT];
        ie_q <= pwdata[PTB_CTRL_IE_BIT];
        rate_q <= pwdata[PTB_CTRL_RATE_LSB +: PTB_RATE_W];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= PTB_STAT_RESET;
      mask_q <= PTB_MASK_RESET;
    end
    else
    begin
      stat_q <= stat_d;
      if (wr_mask)
        mask_q <= pwdata[PTB_EVT_W-1:0];
    end
  end

  // low power reads return zero since the register is locked
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (setup)
      prdata_q <= low_power ? 32'h0 : rd_mux;
  end

  // helper: ticks since enable or since the last event
  logic [STAGES:0] gap_q;
  logic first_q;
  wire [STAGES:0] gap_inc = gap_q + {{STAGES{1'b0}}, 1'b1};
  wire [STAGES:0] full_gap = ({{STAGES{1'b0}}, 1'b1} << tap);
  wire [STAGES:0] half_gap = full_gap >> 1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q <= '0;
      first_q <= 1'b1;
    end
    else if (!on_q)
    begin
      gap_q <= '0;
      first_q <= 1'b1;
    end
    else if (tap_evt)
    begin
      gap_q <= '0;
      first_q <= 1'b0;
    end
    else if (tick)
      gap_q <= gap_inc;
  end

  sequence s_ack_write;
    wr_ctrl && pwdata[PTB_CTRL_ACK_BIT] && !tap_evt;
  endsequence

  sequence s_ctrl_read;
    setup && !pwrite && hit_ctrl && !low_power ##1 access;
  endsequence

  sequence s_locked_access;
    access && low_power;
  endsequence

  a_disabled_holds_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    !on_q |=> cnt_q == '0 && !tap_evt)
    else $error("counter not held at zero while disabled");

  a_tap_sets_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    tap_evt |=> flag_q)
    else $error("overflow did not set the period flag");

  a_irq_from_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    (flag_q && ie_q) |-> irq)
    else $error("flag and enable without interrupt");

  a_ack_clears_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ack_write |=> !flag_q)
    else $error("acknowledge did not clear the flag");

  a_ack_reads_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_read |-> prdata[PTB_CTRL_ACK_BIT] == 1'b0)
    else $error("acknowledge bit read back as one");

  a_event_spacing: assert property (
    @(posedge pclk) disable iff (!presetn)
    tap_evt |-> gap_inc == (first_q ? half_gap : full_gap))
    else $error("period event at wrong tick count");

  a_stop_freezes: assert property (
    @(posedge pclk) disable iff (!presetn)
    (stop_mode && !osc_run_in_stop && on_q)[*2] |-> $stable(cnt_q))
    else $error("counter moved in stop without oscillator");

  a_locked_register: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_locked_access |-> pslverr ##1 $stable({on_q, ie_q, rate_q, mask_q}))
    else $error("register changed during wait or stop");

  a_flag_only_by_tap: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(flag_q) |-> $past(tap_evt))
    else $error("flag rose without an overflow");

endmodule : ptb_timebase

`default_nettype wire

/* ptb_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ptb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic crystal_clock, prescale128_option, osc_run_in_stop;
  logic wait_mode, stop_mode, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fail_count, samples_checked, cycles;

  ptb_timebase u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_clock(crystal_clock), .prescale128_option(prescale128_option),
    .osc_run_in_stop(osc_run_in_stop), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .irq(irq));

  initial
  begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end

  task results;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // hang guard, well above the longest sequence (about 46k cycles)
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      results();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xf

  // one crystal period spans eight pclk cycles
  task tk(input int n);
    repeat (2 * n)
    begin
      repeat (4) @(posedge pclk);
      crystal_clock <= ~crystal_clock;
    end
  endtask : tk

  // restart from zero, expect first flag after n crystal periods
  task ev(input logic [7:0] cfg, input int n);
    xf(1, PTB_ADDR_CTRL, 32'h08);
    xf(1, PTB_ADDR_CTRL, {24'h0, cfg});
    tk(n - 1);
    xf(0, PTB_ADDR_CTRL, 0);
    chk("early", rd, {24'h0, cfg});
    tk(1);
    xf(0, PTB_ADDR_CTRL, 0);
    chk("flag", rd, {24'h0, cfg | 8'h80});
  endtask : ev

  initial
  begin
    {psel, penable, pwrite, crystal_clock, prescale128_option} = '0;
    {osc_run_in_stop, wait_mode, stop_mode, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xf(0, PTB_ADDR_CTRL, 0);
    chk("ctrl", rd, 0);
    chk("okerr", err, 0);
    chk("ready", pready, 1);
    xf(0, PTB_ADDR_MASK, 0);
    chk("mask", rd, 0);
    xf(0, 12'hffc, 0);
    chk("unmapped", {rd[30:0], err}, 1);
    xf(1, PTB_ADDR_MASK, 1);
    ev(8'h76, 4);
    chk("irq", irq, 1);
    xf(0, PTB_ADDR_STAT, 0);
    chk("stat", rd, 1);
    // status now read clear, so only flag and enable hold irq up
    chk("irqflag", irq, 1);
    xf(1, PTB_ADDR_CTRL, 32'h76);
    xf(0, PTB_ADDR_CTRL, 0);
    chk("ack0", rd, 32'hf6);
    xf(1, PTB_ADDR_CTRL, 32'h7e);
    xf(0, PTB_ADDR_CTRL, 0);
    chk("ack1", rd, 32'h76);
    chk("irqoff", irq, 0);
    tk(7);
    xf(0, PTB_ADDR_CTRL, 0);
    chk("period", rd, 32'h76);
    tk(1);
    xf(0, PTB_ADDR_CTRL, 0);
    chk("period", rd, 32'hf6);
    tk(7);
    xf(0, PTB_ADDR_CTRL, 0);
    chk("pending", rd, 32'hf6);
    // crystal rise now lands its tick in the access cycle of the ack
    crystal_clock <= 1'b1;
    xf(1, PTB_ADDR_CTRL, 32'h7e);
    xf(0, PTB_ADDR_CTRL, 0);
    chk("collide", rd, 32'hf6);
    crystal_clock <= 1'b0;
    for (int c = 3; c < 7; c++)
      ev({1'b0, 3'(c), 4'h2}, 1 << (9 - c));
    ev(8'h12, 4096);
    ev(8'h22, 1024);
    // irq enable is off here, so only the masked status path drives irq
    chk("evirq", irq, 1);
    prescale128_option <= 1'b1;
    ev(8'h72, 512);
    prescale128_option <= 1'b0;
    wait_mode <= 1'b1;
    xf(1, PTB_ADDR_CTRL, 0);
    chk("locked", err, 1);
    wait_mode <= 1'b0;
    xf(0, PTB_ADDR_CTRL, 0);
    chk("kept", rd, 32'hf2);
    xf(0, PTB_ADDR_STAT, 0);
    chk("refused", rd[1], 1);
    xf(1, PTB_ADDR_CTRL, 32'h08);
    xf(1, PTB_ADDR_CTRL, 32'h76);
    stop_mode <= 1'b1;
    tk(8);
    chk("stopped", irq, 0);
    osc_run_in_stop <= 1'b1;
    tk(4);
    chk("wake", irq, 1);
    stop_mode <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xf(0, PTB_ADDR_CTRL, 0);
    chk("rst2", rd, 0);
    chk("rst2irq", irq, 0);
    results();
  end
endmodule : tb

`default_nettype wire
